/* File: hw/mgp_port.v */
// Masked 32-bit GPIO port with per-pin edge/level interrupts, AXI4-Lite slave
// Assumes pads and pad function select outside; pin inputs are asynchronous
// Overview of operation
// - 32-bit registers, port uses low PIN_COUNT bits
// - Three instances at 0x5000/5001/5002 0000
// - Gate affects data registers, not direction/interrupts
// - Gate bit 0 allows, 1 blocks
// - Gated bits ignore drive writes and strobes
// - Gated bits read zero from live/drive
// - Live level reads every ungated digital pin
// - Analog selection makes live bit invalid
// - Drive value reaches pin only as GPIO output
// - Drive value reads stored contents
// - Strobes modify stored drive value only
// - Set strobe ones force drive high
// - Set strobe effect needs GPIO and output
// - Flip strobe ones toggle drive bits
// - Reset: inputs, all config registers zero
// - Pin interrupt: falling, rising, both, level
// - Clear strobe ones force drive low
// - Sense 0 edge, 1 level
// - Dual edge 1 triggers on both edges
`timescale 1ns/1ps
`default_nettype none
`include "mgp_defs.vh"
module mgp_port #(
  parameter PORT_INDEX = 0,
  parameter PIN_COUNT  = 32
) (
  input  wire        mclk,
  input  wire        reset_n,
  input  wire [31:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [31:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire [31:0] padIn,
  input  wire [31:0] gpioFunctionSel,
  input  wire [31:0] analogFunctionSel,
  output reg  [31:0] padOut,
  output reg  [31:0] padOe,
  output reg         portIrq
);

  localparam [31:0] USED = (PIN_COUNT >= 32) ? 32'hFFFFFFFF : ((32'h00000001 << PIN_COUNT) - 32'h00000001);
  localparam [31:0] BASE = (PORT_INDEX == 2) ? `MGP_BASE_PORT2 :
                           (PORT_INDEX == 1) ? `MGP_BASE_PORT1 : `MGP_BASE_PORT0;

  function inWindow;
    input [31:0] a;
    begin
      inWindow = ((a & `MGP_WIN_MASK) == BASE);
    end
  endfunction

  function [31:0] laneMask;
    input [3:0] s;
    begin
      laneMask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    end
  endfunction

  // Byte-lane merge for read/write configuration registers
  function [31:0] mergeLanes;
    input [31:0] old;
    input [3:0]  s;
    input [31:0] bits;
    begin
      mergeLanes = (old & ~laneMask(s)) | bits;
    end
  endfunction

  // Aligned, mapped and outside the hole
  function legalOffset;
    input [11:0] off;
    begin
      legalOffset = (off <= `MGP_OFF_RSVD) && (off[1:0] == 2'h0) &&
                    !((off > `MGP_OFF_FLIP) && (off < `MGP_OFF_DIR));
    end
  endfunction

  reg  [31:0] gate_r;
  reg  [31:0] drive_r;
  reg  [31:0] dir_r;
  reg  [31:0] sense_r;
  reg  [31:0] dual_r;
  reg  [31:0] pol_r;
  reg  [31:0] ien_r;
  reg  [31:0] pinMeta_r;
  reg  [31:0] pinSync_r;
  reg  [31:0] pinPrev_r;
  reg  [31:0] awAddr_r;
  reg         awHave_r;
  reg  [31:0] wData_r;
  reg  [3:0]  wStrb_r;
  reg         wHave_r;

  reg  [31:0] drive_nxt;
  reg  [31:0] rdata_nxt;
  reg         rdOk;

  wire        doWrite = awHave_r && wHave_r && !s_axi_bvalid;
  wire [11:0] wOff    = awAddr_r[11:0];
  wire        wInWin  = inWindow(awAddr_r);
  wire [31:0] wBits   = wData_r & laneMask(wStrb_r) & USED;
  wire [31:0] open    = ~gate_r & USED;

  // Channel handshakes
  wire        awTake  = s_axi_awvalid && s_axi_awready;
  wire        wTake   = s_axi_wvalid && s_axi_wready;
  wire        bDone   = s_axi_bvalid && s_axi_bready;
  wire        arTake  = s_axi_arvalid && s_axi_arready;
  wire        rDone   = s_axi_rvalid && s_axi_rready;

  // Completed write aimed at one offset of this window
  function wrHit;
    input [11:0] off;
    begin
      wrHit = doWrite && wInWin && (wOff == off);
    end
  endfunction

  // Write strobes per target register
  wire        wrGate  = wrHit(`MGP_OFF_GATE);
  wire        wrDrive = wrHit(`MGP_OFF_DRIVE);
  wire        wrHigh  = wrHit(`MGP_OFF_HIGH);
  wire        wrLow   = wrHit(`MGP_OFF_LOW);
  wire        wrFlip  = wrHit(`MGP_OFF_FLIP);
  wire        wrDir   = wrHit(`MGP_OFF_DIR);
  wire        wrSense = wrHit(`MGP_OFF_SENSE);
  wire        wrDual  = wrHit(`MGP_OFF_DUAL);
  wire        wrPol   = wrHit(`MGP_OFF_POL);
  wire        wrIen   = wrHit(`MGP_OFF_IEN);
  wire        wrIclr  = wrHit(`MGP_OFF_ICLR);

  // Analog-selected pins read as invalid (zero)
  wire [31:0] liveLevel = pinSync_r & ~analogFunctionSel & USED;

  wire [31:0] iclr    = wrIclr ? wBits : 32'h00000000;
  wire [31:0] edgeHit;
  wire [31:0] levelHit;
  wire [31:0] rawFlags;
  wire [31:0] gatedFlags;

  // No edge until the sync chain holds real pad levels
  reg  [`MGP_WARM_STAGES-1:0] warm_r;
  wire                        histValid = warm_r[`MGP_WARM_STAGES-1];

  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      warm_r <= {`MGP_WARM_STAGES{1'b0}};
    end else begin
      warm_r <= {warm_r[`MGP_WARM_STAGES-2:0], 1'b1};
    end
  end

  // Per-pin interrupt slice
  genvar gi;
  generate
    for (gi = 0; gi < `MGP_REG_WIDTH; gi = gi + 1) begin : g_pin
      wire risen;
      wire fallen;
      reg  flag_r;
      assign risen  = pinSync_r[gi] & ~pinPrev_r[gi] & histValid;
      assign fallen = ~pinSync_r[gi] & pinPrev_r[gi] & histValid;
      assign edgeHit[gi]  = dual_r[gi] ? (risen | fallen) : (pol_r[gi] ? risen : fallen);
      assign levelHit[gi] = ~(pinSync_r[gi] ^ pol_r[gi]);
      // New edge wins over a clear in the same cycle
      always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
          flag_r <= 1'b0;
        end else begin
          flag_r <= ((flag_r & ~iclr[gi]) | edgeHit[gi]) & ~sense_r[gi] & USED[gi];
        end
      end
      // Sense selects level or latched edge
      assign rawFlags[gi]   = (sense_r[gi] ? levelHit[gi] : flag_r) & USED[gi];
      // Gated flag is raw AND enable
      assign gatedFlags[gi] = rawFlags[gi] & ien_r[gi];
    end
  endgenerate

  // Drive value update
  always @* begin
    drive_nxt = drive_r;
    if (wrDrive) begin
      drive_nxt = (drive_r & ~(open & laneMask(wStrb_r))) | (wBits & open);
    end
    if (wrHigh) begin
      drive_nxt = drive_r | (wBits & open);
    end
    if (wrLow) begin
      drive_nxt = drive_r & ~(wBits & open);
    end
    if (wrFlip) begin
      drive_nxt = drive_r ^ (wBits & open);
    end
  end

  // Read mux
  always @* begin
    rdata_nxt = 32'h00000000;
    rdOk      = inWindow(s_axi_araddr);
    case (s_axi_araddr[11:0])
      `MGP_OFF_GATE:  rdata_nxt = gate_r;
      // Live level of every ungated digital pin
      `MGP_OFF_LIVE:  rdata_nxt = liveLevel & open;
      `MGP_OFF_DRIVE: rdata_nxt = drive_r & open;
      `MGP_OFF_HIGH:  rdata_nxt = 32'h00000000;
      `MGP_OFF_LOW:   rdata_nxt = 32'h00000000;
      `MGP_OFF_FLIP:  rdata_nxt = 32'h00000000;
      `MGP_OFF_DIR:   rdata_nxt = dir_r;
      `MGP_OFF_SENSE: rdata_nxt = sense_r;
      `MGP_OFF_DUAL:  rdata_nxt = dual_r;
      `MGP_OFF_POL:   rdata_nxt = pol_r;
      `MGP_OFF_IEN:   rdata_nxt = ien_r;
      `MGP_OFF_RAW:   rdata_nxt = rawFlags;
      `MGP_OFF_GATED: rdata_nxt = gatedFlags;
      `MGP_OFF_ICLR:  rdata_nxt = 32'h00000000;
      `MGP_OFF_RSVD:  rdata_nxt = 32'h00000000;
      default:        rdOk = 1'b0;
    endcase
  end

  // Pin synchroniser and edge history
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      pinMeta_r <= `MGP_RST_WORD;
      pinSync_r <= `MGP_RST_WORD;
      pinPrev_r <= `MGP_RST_WORD;
    end else begin
      pinMeta_r <= padIn;
      pinSync_r <= pinMeta_r;
      pinPrev_r <= pinSync_r;
    end
  end

  // AXI write channel capture and response
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      awAddr_r      <= `MGP_RST_WORD;
      awHave_r      <= 1'b0;
      wData_r       <= `MGP_RST_WORD;
      wStrb_r       <= 4'h0;
      wHave_r       <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `MGP_RESP_OKAY;
    end else begin
      s_axi_awready <= !awHave_r && !s_axi_awready && !awTake && !s_axi_bvalid;
      s_axi_wready  <= !wHave_r && !s_axi_wready && !wTake && !s_axi_bvalid;
      if (awTake) begin
        awAddr_r <= s_axi_awaddr;
        awHave_r <= 1'b1;
      end
      if (wTake) begin
        wData_r <= s_axi_wdata;
        wStrb_r <= s_axi_wstrb;
        wHave_r <= 1'b1;
      end
      if (doWrite) begin
        awHave_r     <= 1'b0;
        wHave_r      <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (wInWin && legalOffset(wOff)) ? `MGP_RESP_OKAY : `MGP_RESP_SLVERR;
      end else if (bDone) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Register writes
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      gate_r  <= `MGP_RST_WORD;
      drive_r <= `MGP_RST_WORD;
      dir_r   <= `MGP_RST_WORD;
      sense_r <= `MGP_RST_WORD;
      dual_r  <= `MGP_RST_WORD;
      pol_r   <= `MGP_RST_WORD;
      ien_r   <= `MGP_RST_WORD;
    end else begin
      drive_r <= drive_nxt;
      if (wrGate) begin
        gate_r <= mergeLanes(gate_r, wStrb_r, wBits);
      end
      if (wrDir) begin
        dir_r <= mergeLanes(dir_r, wStrb_r, wBits);
      end
      if (wrSense) begin
        sense_r <= mergeLanes(sense_r, wStrb_r, wBits);
      end
      if (wrDual) begin
        dual_r <= mergeLanes(dual_r, wStrb_r, wBits);
      end
      if (wrPol) begin
        pol_r <= mergeLanes(pol_r, wStrb_r, wBits);
      end
      if (wrIen) begin
        ien_r <= mergeLanes(ien_r, wStrb_r, wBits);
      end
    end
  end

  // AXI read channel
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= `MGP_RST_WORD;
      s_axi_rresp   <= `MGP_RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && !arTake;
      if (arTake) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rdOk ? rdata_nxt : 32'h00000000;
        s_axi_rresp  <= rdOk ? `MGP_RESP_OKAY : `MGP_RESP_SLVERR;
      end else if (rDone) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Pad drive and combined interrupt
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      padOut  <= `MGP_RST_WORD;
      padOe   <= `MGP_RST_WORD;
      portIrq <= 1'b0;
    end else begin
      // Strobe effect needs GPIO and output
      padOut  <= drive_nxt & dir_r & gpioFunctionSel & USED;
      padOe   <= dir_r & gpioFunctionSel & USED;
      portIrq <= |gatedFlags;
    end
  end

endmodule // mgp_port
`default_nettype wire

/* File: hw/mgp_defs.vh */
// Register map, field widths and reset values of the masked GPIO port
// Assumes inclusion by bare name from the design file
`ifndef MGP_DEFS_VH
`define MGP_DEFS_VH
`define MGP_BASE_PORT0   32'h50000000
`define MGP_BASE_PORT1   32'h50010000
`define MGP_BASE_PORT2   32'h50020000
`define MGP_WIN_MASK     32'hFFFF0000
`define MGP_OFF_GATE     12'h000
`define MGP_OFF_LIVE     12'h004
`define MGP_OFF_DRIVE    12'h008
`define MGP_OFF_HIGH     12'h00C
`define MGP_OFF_LOW      12'h010
`define MGP_OFF_FLIP     12'h014
`define MGP_OFF_DIR      12'h020
`define MGP_OFF_SENSE    12'h024
`define MGP_OFF_DUAL     12'h028
`define MGP_OFF_POL      12'h02C
`define MGP_OFF_IEN      12'h030
`define MGP_OFF_RAW      12'h034
`define MGP_OFF_GATED    12'h038
`define MGP_OFF_ICLR     12'h03C
`define MGP_OFF_RSVD     12'h040
`define MGP_RST_WORD     32'h00000000
`define MGP_RESP_OKAY    2'h0
`define MGP_RESP_SLVERR  2'h2
`define MGP_REG_WIDTH    32
`define MGP_WARM_STAGES  3
`endif

/* File: sim/mgp_port_asserts.sv */
// Concurrent checks on the masked GPIO port pins and bus handshakes
// Assumes a bind onto mgp_port in a single mclk domain
`timescale 1ns/1ps
`default_nettype none
module mgp_port_asserts (
  input wire logic        mclk,
  input wire logic        reset_n,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic [31:0] gpioFunctionSel,
  input wire logic [31:0] padOut,
  input wire logic [31:0] padOe,
  input wire logic        portIrq
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  sequence awTaken; s_axi_awvalid && s_axi_awready; endsequence
  sequence arTaken; s_axi_arvalid && s_axi_arready; endsequence
  a_oe_reset: assert property ($rose(reset_n) |-> padOe == 32'h0 && !portIrq)
    else $error("pins driven after reset");
  a_out_gated: assert property ((padOut & ~padOe) == 32'h0)
    else $error("level on undriven pin");
  a_oe_func: assert property ((padOe & ~$past(gpioFunctionSel)) == 32'h0)
    else $error("non-GPIO pin driven");
  a_out_cause: assert property ($changed(padOut) |-> s_axi_bvalid || $past(s_axi_bvalid) ||
    $past(gpioFunctionSel) != $past(gpioFunctionSel, 2)) else $error("pin level moved without write");
  a_ar_pulse: assert property (s_axi_arready |=> !s_axi_arready)
    else $error("arready longer than one cycle");
  a_r_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while data pending");
  a_b_answer: assert property (awTaken |-> ##[1:2] s_axi_bvalid)
    else $error("write response late");
  a_r_answer: assert property (arTaken |=> s_axi_rvalid)
    else $error("read data late");
endmodule // mgp_port_asserts
`default_nettype wire

/* File: sim/mgp_pads.sv */
// Pad model: resolves each pin from port drive and the outside level
// Assumes the outside level is driven by the bench
`timescale 1ns/1ps
`default_nettype none
module mgp_pads (
  input wire logic [31:0] padOut,
  input wire logic [31:0] padOe,
  input wire logic [31:0] extLevel,
  output logic     [31:0] padIn
);
  assign padIn = (padOut & padOe) | (extLevel & ~padOe);
endmodule // mgp_pads
`default_nettype wire

/* File: sim/masked_gpio_port_test.sv */
// Self-checking bench for port 0 of the masked GPIO port
// Assumes mgp_port, mgp_pads and the checker are compiled first
`timescale 1ns/1ps
`default_nettype none
`include "mgp_defs.vh"
module masked_gpio_port_test;
  logic        mclk = 0, reset_n = 0;
  logic [31:0] s_axi_awaddr = 0, s_axi_wdata = 0, s_axi_araddr = 0, ext = 0;
  logic [31:0] gpioFunctionSel = 0, analogFunctionSel = 0;
  logic [31:0] padIn, padOut, padOe, s_axi_rdata, got, g = 0, d = 0, r = 0, v;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, portIrq;
  logic [11:0] rz [10] = '{12'h000, 12'h008, 12'h00C, 12'h020, 12'h024, 12'h028, 12'h02C, 12'h030, 12'h034, 12'h038};
  logic [11:0] ops [4] = '{12'h008, 12'h00C, 12'h010, 12'h014};
  logic [4:0]  mt [4] = '{5'h10, 5'h1C, 5'h1A, 5'h0D};
  integer      seed = 32'h5fef;
  int          n_mismatch = 0, num_checks = 0, k, j;
  mgp_port u_dut (.*);
  mgp_pads u_pads (.padOut(padOut), .padOe(padOe), .extLevel(ext), .padIn(padIn));
  initial forever #4 mclk = ~mclk;
  task chk(input string n, input [31:0] e, input [31:0] s);
    num_checks++;
    if (e !== s) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task wr(input [11:0] o, input [31:0] x);
    logic a, b, ta, tw;
    @(posedge mclk);
    s_axi_awaddr <= {20'h50000, o}; s_axi_wdata <= x;
    s_axi_awvalid <= 1; s_axi_wvalid <= 1; s_axi_bready <= 1;
    a = 0; b = 0;
    while (!(a && b)) begin
      @(negedge mclk); ta = s_axi_awready; tw = s_axi_wready;
      @(posedge mclk);
      if (ta) s_axi_awvalid <= 0;
      if (tw) s_axi_wvalid <= 0;
      a = a | ta; b = b | tw;
    end
    do @(negedge mclk); while (!s_axi_bvalid);
    rsp = s_axi_bresp;
    @(posedge mclk) s_axi_bready <= 0;
  endtask
  task rd(input [11:0] o, input [31:0] e);
    @(posedge mclk);
    s_axi_araddr <= {20'h50000, o}; s_axi_arvalid <= 1; s_axi_rready <= 1;
    do @(negedge mclk); while (!s_axi_arready);
    @(posedge mclk) s_axi_arvalid <= 0;
    do @(negedge mclk); while (!s_axi_rvalid);
    got = s_axi_rdata; rsp = s_axi_rresp;
    @(posedge mclk) s_axi_rready <= 0;
    chk($sformatf("reg %h", o), e, got);
  endtask
  task wrap_up;
    if (n_mismatch == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge mclk);
    n_mismatch++;
    wrap_up;
  end
  initial begin
    repeat (6) @(posedge mclk);
    reset_n <= 1; gpioFunctionSel <= $random(seed);
    foreach (rz[i]) rd(rz[i], 32'h0);
    chk("padOe", 32'h0, padOe);
    rd(12'h018, 32'h0);
    chk("rresp", {30'h0, `MGP_RESP_SLVERR}, {30'h0, rsp});
    for (k = 0; k < 4; k++) begin
      g = $random(seed); r = $random(seed);
      wr(12'h000, g); wr(12'h020, r);
      for (j = 0; j < 4; j++) begin
        v = $random(seed);
        wr(ops[j], v);
        case (j)
          0: d = (d & g) | (v & ~g);
          1: d = d | (v & ~g);
          2: d = d & ~(v & ~g);
          default: d = d ^ (v & ~g);
        endcase
        rd(12'h008, d & ~g);
        chk("padOut", d & r & gpioFunctionSel, padOut);
        chk("padOe", r & gpioFunctionSel, padOe);
      end
      ext <= $random(seed); analogFunctionSel <= $random(seed);
      repeat (4) @(posedge mclk);
      v = r & gpioFunctionSel;
      rd(12'h004, ((d & v) | (ext & ~v)) & ~g & ~analogFunctionSel);
    end
    wr(12'h01C, 32'hFFFFFFFF);
    chk("bresp", {30'h0, `MGP_RESP_SLVERR}, {30'h0, rsp});
    wr(12'h000, 32'hFFFFFFFF); wr(12'h020, 32'h0000FFFF);
    rd(12'h020, 32'h0000FFFF);
    wr(12'h020, 32'h0); ext <= 0; analogFunctionSel <= 0;
    for (k = 0; k < 4; k++) begin
      wr(12'h024, {31'h0, mt[k][0]}); wr(12'h028, {31'h0, mt[k][1]});
      wr(12'h02C, {31'h0, mt[k][2]}); wr(12'h030, {31'h0, k[0]}); wr(12'h03C, 32'hFFFFFFFF);
      ext <= 32'h1;
      repeat (6) @(posedge mclk);
      rd(12'h034, {31'h0, mt[k][3]});
      chk("portIrq", {31'h0, mt[k][3] & k[0]}, {31'h0, portIrq});
      ext <= 32'h0;
      repeat (6) @(posedge mclk);
      rd(12'h034, {31'h0, mt[k][4]});
      rd(12'h038, {31'h0, mt[k][4] & k[0]});
      wr(12'h03C, 32'hFFFFFFFF);
      rd(12'h034, 32'h0);
    end
    wrap_up;
  end
endmodule // masked_gpio_port_test
bind mgp_port mgp_port_asserts u_chk (.*);
`default_nettype wire
